// [verilog/psam_consts.svh]
// Purpose : Constants for the program space address map block
// Assumes : Avalon-MM register window, 32-bit data, byte addresses
// Notes   : Offsets are byte addresses of aligned words
//
// Summary of operation
// RL1: Extended data space is split into pages of 32 Kbytes each.
// RL2: Data reads use the read page, writes the write page; program view reads only.
// RL3: Page value joined with data address<14:0> forms a 24-bit address.
// RL4: Page 0 through the extended window raises an address error trap.
// RL5: Table page (8 bits) sits above the 16-bit address: 24-bit program address.
// RL6: Table page bit 7 low targets user memory, high targets configuration memory.
// RL7: Read page is 10 bits and picks a 16K word program page when remapping.
// RL8: Address MSb and read page bit 9 set: page<7:0> with address<14:0>, 23 bits.
// RL9: Read page bit 8 picks low word (0) or high word (1) of program memory.
// RL10: Remapped accesses stay in user memory, never configuration memory.
// RL11: While remapping, address bit 15 is ignored; read page bit 0 supplies it.
// RL12: Table operations reach every byte of a program word, byte or word wide.
// RL13: Remapped program view is read-only; writes through it are refused.
// RL14: Program space is 24 bits wide, data space 16 bits, alignment kept.
// RL15: Addresses with MSb low bypass paging and go to base data memory.
`ifndef PSAM_CONSTS_SVH
`define PSAM_CONSTS_SVH

`define PSAM_OFF_RD_PAGE    5'h00
`define PSAM_OFF_WR_PAGE    5'h04
`define PSAM_OFF_TBL_PAGE   5'h08
`define PSAM_OFF_STATUS     5'h0c
`define PSAM_OFF_MASK       5'h10

`define PSAM_RD_PAGE_W      10
`define PSAM_WR_PAGE_W      9
`define PSAM_TBL_PAGE_W     8
`define PSAM_EV_W           3
`define PSAM_RD_PAGE_RST    10'h001
`define PSAM_WR_PAGE_RST    9'h001
`define PSAM_TBL_PAGE_RST   8'h00

`define PSAM_EV_PAGE0       0
`define PSAM_EV_RO          1
`define PSAM_EV_CFG         2

`define PSAM_REMAP_BIT      9
`define PSAM_HI_WORD_BIT    8
`define PSAM_CFG_BIT        7
`define PSAM_ADDR_MSB       15

`endif

// [verilog/psam_pkg.sv]
// Purpose : Types for the program space address map block
// Assumes : Nothing beyond the constants header
// Notes   : Enumerations only
package psam_pkg;

  typedef enum logic [1:0] {
    KIND_DATA_RD,
    KIND_DATA_WR,
    KIND_TBL_RD,
    KIND_TBL_WR
  } psam_kind_t;

  typedef enum logic [2:0] {
    ROUTE_BASE,
    ROUTE_PAGED,
    ROUTE_REMAP,
    ROUTE_TBL,
    ROUTE_ERR
  } psam_route_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } psam_bus_t;

endpackage : psam_pkg

// [verilog/psam_xlate.sv]
// Purpose : Combinational address translation for one access
// Assumes : Page values are stable while the request is presented
// Notes   : Pure logic; the caller registers the results
`timescale 1ns/1ps
`default_nettype none
`include "psam_consts.svh"

module psam_xlate
  import psam_pkg::*;
(
  input  wire logic [1:0]                  kind_i,
  input  wire logic [15:0]                 addr_i,
  input  wire logic [`PSAM_RD_PAGE_W-1:0]  rd_page_i,
  input  wire logic [`PSAM_WR_PAGE_W-1:0]  wr_page_i,
  input  wire logic [`PSAM_TBL_PAGE_W-1:0] tbl_page_i,
  output logic      [2:0]                  route_o,
  output logic      [23:0]                 prog_addr_o,
  output logic      [23:0]                 data_addr_o,
  output logic                             word_hi_o,
  output logic                             cfg_o,
  output logic                             err_page0_o,
  output logic                             err_ro_o
);

  always_comb
  begin
    route_o     = ROUTE_BASE;
    prog_addr_o = 24'h000000;
    data_addr_o = {8'h00, addr_i};                                   // [RL15] [RL14]
    word_hi_o   = 1'b0;
    cfg_o       = 1'b0;
    err_page0_o = 1'b0;
    err_ro_o    = 1'b0;
    if (kind_i == KIND_TBL_RD || kind_i == KIND_TBL_WR)
    begin
      route_o     = ROUTE_TBL;
      prog_addr_o = {tbl_page_i, addr_i};                            // [RL5] [RL12]
      cfg_o       = tbl_page_i[`PSAM_CFG_BIT];                       // [RL6]
    end
    else if (addr_i[`PSAM_ADDR_MSB])
    begin
      if (kind_i == KIND_DATA_RD && rd_page_i[`PSAM_REMAP_BIT])
      begin
        // Bit 15 of the program address comes from page bit 0
        route_o     = ROUTE_REMAP;
        prog_addr_o = {1'b0, rd_page_i[7:0], addr_i[14:0]};          // [RL7] [RL8] [RL11] [RL10]
        word_hi_o   = rd_page_i[`PSAM_HI_WORD_BIT];                  // [RL9]
      end
      else if (kind_i == KIND_DATA_RD)
      begin
        if (rd_page_i[8:0] == 9'h000)
        begin
          route_o     = ROUTE_ERR;
          err_page0_o = 1'b1;                                        // [RL4]
        end
        else
        begin
          route_o     = ROUTE_PAGED;
          data_addr_o = {rd_page_i[8:0], addr_i[14:0]};              // [RL1] [RL2] [RL3]
        end
      end
      else if (wr_page_i == 9'h000)
      begin
        // Page 0 write with the remap bit set aims at read-only program space
        route_o     = ROUTE_ERR;
        err_page0_o = 1'b1;                                          // [RL4]
        err_ro_o    = rd_page_i[`PSAM_REMAP_BIT];                    // [RL13]
      end
      else
      begin
        route_o     = ROUTE_PAGED;
        data_addr_o = {wr_page_i, addr_i[14:0]};                     // [RL2] [RL3]
      end
    end
  end

endmodule : psam_xlate
`default_nettype wire

// [verilog/psam_top.sv]
// Purpose : Paged data and program space address generation with register window
// Assumes : One access request per cycle at most; Avalon-MM master holds requests
// Notes   : Results appear one cycle after the request; outputs are registered
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psam_consts.svh"

module psam_top
  import psam_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Access request from address generation
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  req_kind_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic        req_byte_i,
  input  wire logic        req_tbl_hi_i,
  // Program memory side
  output logic [23:0]      prog_addr_o,
  output logic             prog_rd_o,
  output logic             prog_wr_o,
  output logic             prog_cfg_o,
  output logic             prog_word_hi_o,
  output logic             prog_byte_o,
  // Data memory side
  output logic [23:0]      data_addr_o,
  output logic             data_rd_o,
  output logic             data_wr_o,
  output logic             data_byte_o,
  // Trap and interrupt
  output logic             addr_trap_o,
  output logic             irq_o
);

  // ************************************************************
  // Translation
  // ************************************************************
  logic [`PSAM_RD_PAGE_W-1:0]  rd_page_reg, rd_page_next;
  logic [`PSAM_WR_PAGE_W-1:0]  wr_page_reg, wr_page_next;
  logic [`PSAM_TBL_PAGE_W-1:0] tbl_page_reg, tbl_page_next;
  logic [`PSAM_EV_W-1:0]       status_reg, status_next;
  logic [`PSAM_EV_W-1:0]       mask_reg, mask_next;
  logic [2:0]                  x_route;
  logic [23:0]                 x_prog_addr, x_data_addr;
  logic                        x_word_hi, x_cfg, x_err_page0, x_err_ro;

  psam_xlate u_xlate (
    .kind_i      (req_kind_i),
    .addr_i      (req_addr_i),
    .rd_page_i   (rd_page_reg),
    .wr_page_i   (wr_page_reg),
    .tbl_page_i  (tbl_page_reg),
    .route_o     (x_route),
    .prog_addr_o (x_prog_addr),
    .data_addr_o (x_data_addr),
    .word_hi_o   (x_word_hi),
    .cfg_o       (x_cfg),
    .err_page0_o (x_err_page0),
    .err_ro_o    (x_err_ro)
  );

  // ************************************************************
  // Access outputs
  // ************************************************************
  logic [23:0] prog_addr_reg, prog_addr_next;
  logic        prog_rd_reg, prog_rd_next;
  logic        prog_wr_reg, prog_wr_next;
  logic        prog_cfg_reg, prog_cfg_next;
  logic        prog_hi_reg, prog_hi_next;
  logic        prog_byte_reg, prog_byte_next;
  logic [23:0] data_addr_reg, data_addr_next;
  logic        data_rd_reg, data_rd_next;
  logic        data_wr_reg, data_wr_next;
  logic        data_byte_reg, data_byte_next;
  logic        trap_reg, trap_next;
  logic [`PSAM_EV_W-1:0] ev_set;
  logic        is_write;

  always_comb
  begin
    is_write       = (req_kind_i == KIND_DATA_WR) || (req_kind_i == KIND_TBL_WR);
    prog_addr_next = prog_addr_reg;
    data_addr_next = data_addr_reg;
    prog_cfg_next  = prog_cfg_reg;
    prog_hi_next   = prog_hi_reg;
    prog_byte_next = prog_byte_reg;
    data_byte_next = data_byte_reg;
    prog_rd_next   = 1'b0;
    prog_wr_next   = 1'b0;
    data_rd_next   = 1'b0;
    data_wr_next   = 1'b0;
    trap_next      = 1'b0;
    ev_set         = '0;
    if (req_valid_i)
    begin
      case (x_route)
        ROUTE_BASE, ROUTE_PAGED:
        begin
          data_addr_next = x_data_addr;
          data_byte_next = req_byte_i;
          data_rd_next   = ~is_write;
          data_wr_next   = is_write;
        end
        ROUTE_REMAP:
        begin
          prog_addr_next = x_prog_addr;
          prog_cfg_next  = 1'b0;                                    // [RL10]
          prog_hi_next   = x_word_hi;                               // [RL9]
          prog_byte_next = req_byte_i;
          prog_rd_next   = 1'b1;
        end
        ROUTE_TBL:
        begin
          prog_addr_next = x_prog_addr;
          prog_cfg_next  = x_cfg;                                   // [RL6]
          prog_hi_next   = req_tbl_hi_i;                            // [RL12]
          prog_byte_next = req_byte_i;                              // [RL12]
          prog_rd_next   = ~is_write;
          prog_wr_next   = is_write;
          ev_set[`PSAM_EV_CFG] = x_cfg & is_write;
        end
        ROUTE_ERR:
        begin
          trap_next = 1'b1;                                         // [RL4]
          ev_set[`PSAM_EV_PAGE0] = x_err_page0;
        end
        default: trap_next = 1'b1;
      endcase
      ev_set[`PSAM_EV_RO] = x_err_ro;                               // [RL13]
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      prog_addr_reg <= 24'h000000;
      prog_rd_reg   <= 1'b0;
      prog_wr_reg   <= 1'b0;
      prog_cfg_reg  <= 1'b0;
      prog_hi_reg   <= 1'b0;
      prog_byte_reg <= 1'b0;
      data_addr_reg <= 24'h000000;
      data_rd_reg   <= 1'b0;
      data_wr_reg   <= 1'b0;
      data_byte_reg <= 1'b0;
      trap_reg      <= 1'b0;
    end
    else
    begin
      prog_addr_reg <= prog_addr_next;
      prog_rd_reg   <= prog_rd_next;
      prog_wr_reg   <= prog_wr_next;
      prog_cfg_reg  <= prog_cfg_next;
      prog_hi_reg   <= prog_hi_next;
      prog_byte_reg <= prog_byte_next;
      data_addr_reg <= data_addr_next;
      data_rd_reg   <= data_rd_next;
      data_wr_reg   <= data_wr_next;
      data_byte_reg <= data_byte_next;
      trap_reg      <= trap_next;
    end
  end

  // ************************************************************
  // Register window
  // ************************************************************
  psam_bus_t   bus_reg, bus_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        irq_reg, irq_next;
  logic        wr_take;
  logic [15:0] wdata;

  always_comb
  begin
    bus_next      = bus_reg;
    rdata_next    = rdata_reg;
    rd_page_next  = rd_page_reg;
    wr_page_next  = wr_page_reg;
    tbl_page_next = tbl_page_reg;
    mask_next     = mask_reg;
    wr_take       = 1'b0;
    wdata         = avs_writedata_i[15:0];
    case (bus_reg)
      BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          bus_next = BUS_ACK;
          case (avs_address_i)
            `PSAM_OFF_RD_PAGE:  rdata_next = {22'h0, rd_page_reg};
            `PSAM_OFF_WR_PAGE:  rdata_next = {23'h0, wr_page_reg};
            `PSAM_OFF_TBL_PAGE: rdata_next = {24'h000000, tbl_page_reg};
            `PSAM_OFF_STATUS:   rdata_next = {29'h0, status_reg};
            `PSAM_OFF_MASK:     rdata_next = {29'h0, mask_reg};
            default:            rdata_next = 32'h00000000;
          endcase
        end
      end
      BUS_ACK:
      begin
        bus_next = BUS_IDLE;
        wr_take  = avs_write_i;
      end
      default: bus_next = BUS_IDLE;
    endcase
    if (wr_take)
    begin
      case (avs_address_i)
        `PSAM_OFF_RD_PAGE:
        begin
          if (avs_byteenable_i[0]) rd_page_next[7:0] = wdata[7:0];
          if (avs_byteenable_i[1]) rd_page_next[9:8] = wdata[9:8];  // [RL7]
        end
        `PSAM_OFF_WR_PAGE:
        begin
          if (avs_byteenable_i[0]) wr_page_next[7:0] = wdata[7:0];
          if (avs_byteenable_i[1]) wr_page_next[8] = wdata[8];
        end
        `PSAM_OFF_TBL_PAGE: if (avs_byteenable_i[0]) tbl_page_next = wdata[7:0]; // [RL5]
        `PSAM_OFF_MASK:     if (avs_byteenable_i[0]) mask_next = wdata[2:0];
        default:            mask_next = mask_reg;
      endcase
    end
  end

  // Sticky events: a new event in the clearing cycle survives
  genvar gi;
  generate
    for (gi = 0; gi < `PSAM_EV_W; gi = gi + 1)
    begin : g_ev
      assign status_next[gi] = ev_set[gi] | (status_reg[gi] & ~(wr_take
        && avs_address_i == `PSAM_OFF_STATUS && avs_byteenable_i[0]
        && avs_writedata_i[gi]));
    end
  endgenerate

  assign irq_next = |(status_next & mask_next);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      bus_reg      <= BUS_IDLE;
      rdata_reg    <= 32'h00000000;
      rd_page_reg  <= `PSAM_RD_PAGE_RST;
      wr_page_reg  <= `PSAM_WR_PAGE_RST;
      tbl_page_reg <= `PSAM_TBL_PAGE_RST;
      status_reg   <= 3'h0;
      mask_reg     <= 3'h0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      bus_reg      <= bus_next;
      rdata_reg    <= rdata_next;
      rd_page_reg  <= rd_page_next;
      wr_page_reg  <= wr_page_next;
      tbl_page_reg <= tbl_page_next;
      status_reg   <= status_next;
      mask_reg     <= mask_next;
      irq_reg      <= irq_next;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = (bus_reg == BUS_IDLE);
  assign prog_addr_o       = prog_addr_reg;
  assign prog_rd_o         = prog_rd_reg;
  assign prog_wr_o         = prog_wr_reg;
  assign prog_cfg_o        = prog_cfg_reg;
  assign prog_word_hi_o    = prog_hi_reg;
  assign prog_byte_o       = prog_byte_reg;
  assign data_addr_o       = data_addr_reg;
  assign data_rd_o         = data_rd_reg;
  assign data_wr_o         = data_wr_reg;
  assign data_byte_o       = data_byte_reg;
  assign addr_trap_o       = trap_reg;
  assign irq_o             = irq_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_base_bypass: assert property (req_valid_i && !req_addr_i[15] && req_kind_i == KIND_DATA_RD
    |=> data_rd_o && data_addr_o == {8'h00, $past(req_addr_i)}) // [RL15]
    else $error("base data read not passed through");
  a_paged_read_addr: assert property (req_valid_i && req_addr_i[15] && !rd_page_reg[9]
    && req_kind_i == KIND_DATA_RD && rd_page_reg[8:0] != 9'h000 |=> data_rd_o
    && data_addr_o == {$past(rd_page_reg[8:0]), $past(req_addr_i[14:0])}) // [RL2]
    else $error("paged read address wrong");
  a_paged_write_addr: assert property (req_valid_i && req_addr_i[15]
    && req_kind_i == KIND_DATA_WR && wr_page_reg != 9'h000
    |=> data_wr_o && data_addr_o[23:15] == $past(wr_page_reg)) // [RL3]
    else $error("paged write address wrong");
  a_page0_trap: assert property (req_valid_i && req_addr_i[15] && req_kind_i == KIND_DATA_WR
    && wr_page_reg == 9'h000 |=> addr_trap_o && !data_wr_o && status_reg[0]) // [RL4]
    else $error("page 0 write did not trap");
  a_remap_addr: assert property (req_valid_i && req_addr_i[15] && req_kind_i == KIND_DATA_RD
    && rd_page_reg[9] |=> prog_rd_o && !prog_cfg_o && prog_addr_o[23] == 1'b0
    && prog_addr_o[22:0] == {$past(rd_page_reg[7:0]), $past(req_addr_i[14:0])}
    && prog_word_hi_o == $past(rd_page_reg[8])) // [RL11]
    else $error("remapped address wrong");
  a_remap_readonly: assert property (req_valid_i && req_addr_i[15] && rd_page_reg[9]
    && req_kind_i == KIND_DATA_WR && wr_page_reg == 9'h000
    |=> !prog_wr_o && !data_wr_o && status_reg[`PSAM_EV_RO]) // [RL13]
    else $error("write reached program space via window");
  a_tbl_addr: assert property (req_valid_i && req_kind_i == KIND_TBL_WR
    |=> prog_wr_o && prog_addr_o == {$past(tbl_page_reg), $past(req_addr_i)}
    && prog_cfg_o == $past(tbl_page_reg[7])) // [RL6]
    else $error("table address wrong");
  a_irq_level: assert property (|(status_reg & mask_reg) |-> irq_o) // [RL4]
    else $error("unmasked event without interrupt");
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer late");

  c_remap_read: cover property (prog_rd_o && !prog_cfg_o && prog_word_hi_o);
  c_trap:     cover property (addr_trap_o ##1 irq_o);
  c_tbl_cfg:  cover property (prog_wr_o && prog_cfg_o);

endmodule : psam_top
`default_nettype wire

// [dv/psam_agu_model.sv]
// Purpose : Address generation and program memory stand-in
// Assumes : One-cycle request pulses taken at the rising edge
// Notes   : Counts program writes so refused writes show up
`timescale 1ns/1ps
`default_nettype none
module psam_agu_model (
  input  wire logic        clk_i,
  input  wire logic        prog_wr_i,
  output logic             valid_o,
  output logic [1:0]       kind_o,
  output logic [15:0]      addr_o,
  output logic             byte_o,
  output logic             hi_o,
  output int               wr_cnt_o
);
  initial
  begin
    valid_o  = 1'b0;
    kind_o   = 2'h0;
    addr_o   = 16'h0000;
    byte_o   = 1'b0;
    hi_o     = 1'b0;
    wr_cnt_o = 0;
  end
  task automatic issue(input logic [1:0] k, input logic [15:0] a, input logic b,
                       input logic h);
    @(posedge clk_i);
    valid_o <= 1'b1;
    kind_o  <= k;
    addr_o  <= a;
    byte_o  <= b;
    hi_o    <= h;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Address no longer qualified: show garbage, not the last value
    addr_o  <= ~a;
  endtask : issue
  always @(posedge clk_i)
    if (prog_wr_i === 1'b1)
      wr_cnt_o <= wr_cnt_o + 1;
endmodule : psam_agu_model
`default_nettype wire

// [dv/test_psam_top.sv]
// Purpose : Self-checking bench for the address map block
// Assumes : One cycle register answer, outputs one cycle after request
// Notes   : No random stimulus
`timescale 1ns/1ps
`default_nettype none
module test_psam_top;
  import psam_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic        valid, rbyte, rhi;
  logic [1:0]  kind;
  logic [15:0] raddr;
  logic [23:0] paddr, daddr;
  logic        prd, pwr, pcfg, phi, pbyte, drd, dwr, dbyte, trap, irq;
  logic [31:0] q;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  int          pw0;
  always #2.5 clk = ~clk;
  psam_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .req_valid_i(valid),
    .req_kind_i(kind), .req_addr_i(raddr), .req_byte_i(rbyte), .req_tbl_hi_i(rhi),
    .prog_addr_o(paddr), .prog_rd_o(prd), .prog_wr_o(pwr), .prog_cfg_o(pcfg),
    .prog_word_hi_o(phi), .prog_byte_o(pbyte), .data_addr_o(daddr), .data_rd_o(drd),
    .data_wr_o(dwr), .data_byte_o(dbyte), .addr_trap_o(trap), .irq_o(irq));
  psam_agu_model agu (.clk_i(clk), .prog_wr_i(pwr), .valid_o(valid), .kind_o(kind),
    .addr_o(raddr), .byte_o(rbyte), .hi_o(rhi), .wr_cnt_o(pw0));
  //**********************************************************************
  // Helpers
  //**********************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic go(input logic [1:0] k, input logic [15:0] a, input logic b, input logic h);
    agu.issue(k, a, b, h);
    @(negedge clk);
  endtask : go
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  //**********************************************************************
  // Sequence
  //**********************************************************************
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 5'h00, 0); chk(q, 32'h001);
    bus(0, 5'h04, 0); chk(q, 32'h001);
    bus(0, 5'h08, 0); chk(q, 32'h000);
    bus(0, 5'h0c, 0); chk(q, 32'h000);
    bus(0, 5'h10, 0); chk(q, 32'h000);
    bus(1, 5'h18, 32'hffffffff); bus(0, 5'h18, 0); chk(q, 32'h0);
    bus(1, 5'h00, 32'hffffffff); bus(0, 5'h00, 0); chk(q, 32'h3ff);
    bus(1, 5'h08, 32'hffffffff); bus(0, 5'h08, 0); chk(q, 32'h0ff);
    // Base data, no paging
    bus(1, 5'h00, 32'h205);
    go(KIND_DATA_RD, 16'h1234, 0, 0);
    chk({drd, prd, daddr[15:0]}, {2'b10, 16'h1234});
    // Remap: page low byte above address<14:0>, address<15> dropped
    go(KIND_DATA_RD, 16'h8004, 0, 0);
    chk({prd, drd, pcfg, phi}, 4'b1000);
    chk(paddr, 24'h028004);
    bus(1, 5'h00, 32'h3ff);
    go(KIND_DATA_RD, 16'hffff, 0, 0);
    chk({prd, pcfg, phi}, 3'b101);
    chk(paddr, 24'h7fffff);
    // Extended data pages, read page and write page kept apart
    bus(1, 5'h00, 32'h003);
    go(KIND_DATA_RD, 16'h8010, 0, 0);
    chk({drd, prd, daddr}, {2'b10, 24'h018010});
    bus(1, 5'h00, 32'h000);
    bus(1, 5'h04, 32'h002);
    go(KIND_DATA_WR, 16'h9000, 1, 0);
    chk({dwr, trap, pwr, dbyte, daddr}, {4'b1001, 24'h011000});
    // Page 0 through the window traps and raises the interrupt once unmasked
    go(KIND_DATA_RD, 16'h8000, 0, 0);
    chk({trap, drd, prd}, 3'b100);
    bus(0, 5'h0c, 0); chk(q & 32'h1, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    bus(1, 5'h10, 32'h1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b1);
    bus(1, 5'h0c, 32'h7);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b0);
    bus(0, 5'h0c, 0); chk(q, 32'h0);
    bus(1, 5'h04, 32'h000);
    go(KIND_DATA_WR, 16'h8000, 0, 0);
    chk({trap, dwr, pwr}, 3'b100);
    // Write through the remapped window is refused
    bus(1, 5'h0c, 32'h7);
    bus(1, 5'h00, 32'h205);
    go(KIND_DATA_WR, 16'h8004, 0, 0);
    chk({pwr, pw0[3:0]}, 5'h0);
    bus(0, 5'h0c, 0); chk(q & 32'h2, 32'h2);
    // Table operations: every byte, user and configuration space
    bus(1, 5'h08, 32'h012);
    go(KIND_TBL_RD, 16'habcd, 1, 1);
    chk({prd, pcfg, phi, pbyte, paddr}, {4'b1011, 24'h12abcd});
    go(KIND_TBL_WR, 16'h0002, 0, 0);
    chk({pwr, pcfg, phi, pbyte, paddr}, {4'b1000, 24'h120002});
    bus(1, 5'h08, 32'h085);
    go(KIND_TBL_RD, 16'h0001, 1, 0);
    chk({pcfg, paddr}, {1'b1, 24'h850001});
    bus(1, 5'h0c, 32'h7);
    go(KIND_TBL_WR, 16'h0010, 0, 1);
    chk({pcfg, phi}, 2'b11);
    bus(0, 5'h0c, 0); chk(q & 32'h4, 32'h4);
    tally_and_finish();
  end
endmodule : test_psam_top
`default_nettype wire
